/* rtl/pic_pkg.sv */
// constants, types and helpers for the eight-input priority interrupt controller
// assumes one 50 MHz clock and an asynchronous active-low reset
`default_nettype none
package pic_pkg;
  // ************************************************************
  // port decode and word fields
  // ************************************************************
  localparam logic [7:0] LOWER_PORT = 8'h20;
  localparam logic [7:0] UPPER_PORT = 8'h21;
  localparam int INIT_SEL_BIT = 4;
  localparam int CMD_SEL_BIT = 3;
  localparam int NO_OPTIONS_BIT = 0;
  localparam int SINGLE_BIT = 1;
  localparam int LEVEL_MODE_BIT = 3;
  localparam int VEC16_BIT = 0;
  localparam int AUTO_EOI_BIT = 1;
  localparam int BUF_SEL_LSB = 2;
  localparam int BUF_ON_BIT = 3;
  localparam int NEST_SPECIAL_BIT = 4;
  localparam int POLL_BIT = 2;
  localparam int VEC_HIGH_LSB = 3;
  // ************************************************************
  // end-of-interrupt and rotation operations, bits 7..5
  // ************************************************************
  localparam logic [2:0] OP_CLR_AUTO_ROT = 3'h0;
  localparam logic [2:0] OP_NONSPEC_EOI = 3'h1;
  localparam logic [2:0] OP_NOP = 3'h2;
  localparam logic [2:0] OP_SPEC_EOI = 3'h3;
  localparam logic [2:0] OP_SET_AUTO_ROT = 3'h4;
  localparam logic [2:0] OP_ROT_NONSPEC = 3'h5;
  localparam logic [2:0] OP_SET_LOWEST = 3'h6;
  localparam logic [2:0] OP_ROT_SPEC = 3'h7;
  // ************************************************************
  // reset values, idle vector level and read selects
  // ************************************************************
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] LOWEST_RESET = 3'h7;
  localparam logic [2:0] DEFAULT_LEVEL = 3'h7;
  localparam logic [1:0] RSEL_PENDING = 2'h2;
  localparam logic [1:0] RSEL_SERVICE = 2'h3;

  typedef enum logic [3:0] {
    ST_READY = 4'h1,
    ST_VECTOR = 4'h2,
    ST_CASCADE = 4'h4,
    ST_OPTIONS = 4'h8
  } init_state_t;

  // level reached after stepping down from the highest priority
  function automatic logic [2:0] prio_level(input logic [2:0] lowest, input logic [2:0] step);
    return 3'(lowest + step + 3'h1);
  endfunction
endpackage
`default_nettype wire

/* rtl/request_latch.sv */
// request capture: edge or level sensitive, one mode shared by all inputs
// assumes request inputs already synchronous to i_clk
`default_nettype none
module request_latch import pic_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_req,
  input wire logic i_level_mode,
  input wire logic i_clear_all,
  input wire logic [WIDTH-1:0] i_ack_clear,
  output logic [WIDTH-1:0] o_pending
);
  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] edge_reg;
  logic [WIDTH-1:0] rise;

  assign rise = i_req & ~prev_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= i_req;
    end
  end

  // a fresh rise beats an acknowledge in the same cycle; dropping the input cancels
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      edge_reg <= '0;
    end else if (i_clear_all) begin
      edge_reg <= '0;
    end else begin
      edge_reg <= ((edge_reg & ~i_ack_clear) | rise) & i_req;
    end
  end

  assign o_pending = i_level_mode ? i_req : edge_reg;

  a_edge_capture: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_level_mode && !i_clear_all && i_req[0] && !prev_reg[0]) ##1 !i_level_mode
      |-> o_pending[0] == i_req[0])
    else $error("rising request not latched");
endmodule
`default_nettype wire

/* rtl/priority_resolver.sv */
// picks the highest-priority serviceable request and the top in-service level
// purely combinational; lowest-priority level sets the rotation
`default_nettype none
module priority_resolver import pic_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] i_request,
  input wire logic [WIDTH-1:0] i_in_service,
  input wire logic [2:0] i_lowest,
  input wire logic i_special_mask,
  input wire logic [WIDTH-1:0] i_nest_pass,
  output logic o_req_valid,
  output logic [2:0] o_req_level,
  output logic o_isr_valid,
  output logic [2:0] o_isr_level
);
  always_comb begin
    logic blocked;
    logic [2:0] p;
    blocked = 1'b0;
    p = 3'h0;
    o_req_valid = 1'b0;
    o_req_level = 3'h0;
    o_isr_valid = 1'b0;
    o_isr_level = 3'h0;
    for (int i = 0; i < WIDTH; i++) begin
      p = prio_level(i_lowest, 3'(i));
      if (!o_isr_valid && i_in_service[p]) begin
        o_isr_valid = 1'b1;
        o_isr_level = p;
      end
      // own level re-enters only under special nesting for a cascaded input
      if (!o_req_valid && !blocked && i_request[p] &&
          (!i_in_service[p] || i_nest_pass[p])) begin
        o_req_valid = 1'b1;
        o_req_level = p;
      end
      // special mask: lower levels are not held off by an active service
      if (i_in_service[p] && !i_special_mask) begin
        blocked = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/interrupt_controller.sv */
// eight-input priority interrupt controller, two i/o ports on the host bus
// assumes strobes, address and requests synchronous to i_clk; one ack pulse per cycle
//
// Contract
// - first init word bit0 low: options word follows
// - bit1 low cascade, takes cascade word
// - bit3 selects edge or level requests
// - bits4,3 clear: eoi and rotation command
// - bit4 clear bit3 set: read/poll/mask command
// - bits2..0 name the targeted level
// - bits7..5 choose one of eight operations
// - read select pending/in-service, bit2 polls
// - bits6,5 leave or enter special mask
// - vector word gives vector bits7..3
// - master cascade word marks slave-attached inputs
// - slave cascade word holds slave identity
// - options bit0 picks 8- or 16-bit mode
// - options bit1 selects automatic end
// - options bits3,2 select buffering
// - options bit4 enables special full nesting
// - upper port loads and reads mask
// - initialization may drop pending requests
`default_nettype none
module interrupt_controller import pic_pkg::*; #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cs,
  input wire logic [7:0] i_addr,
  input wire logic i_io_write_strobe_n,
  input wire logic i_io_read_strobe_n,
  input wire logic [7:0] i_wdata,
  input wire logic [WIDTH-1:0] i_irq,
  input wire logic i_ack,
  input wire logic i_slave_strap,
  input wire logic [2:0] i_cas_id,
  output logic [7:0] o_rdata,
  output logic o_int,
  output logic [7:0] o_vector,
  output logic o_vector_valid,
  output logic [2:0] o_cas_id,
  output logic o_cas_en,
  output logic o_buf_en,
  output logic o_buf_master
);
  // ************************************************************
  // bus decode
  // ************************************************************
  logic wr_prev_reg;
  logic rd_prev_reg;
  logic wr_take;
  logic rd_take;
  logic lower_sel;
  logic upper_sel;
  logic init_write;
  logic eoi_write;
  logic rpm_write;
  logic upper_write;

  assign lower_sel = i_cs && (i_addr == LOWER_PORT);
  assign upper_sel = i_cs && (i_addr == UPPER_PORT);
  assign wr_take = (lower_sel || upper_sel) && !i_io_write_strobe_n && wr_prev_reg;
  assign rd_take = (lower_sel || upper_sel) && !i_io_read_strobe_n && rd_prev_reg;
  assign init_write = wr_take && lower_sel && i_wdata[INIT_SEL_BIT];
  assign eoi_write = wr_take && lower_sel && !i_wdata[INIT_SEL_BIT]
                     && !i_wdata[CMD_SEL_BIT];
  assign rpm_write = wr_take && lower_sel && !i_wdata[INIT_SEL_BIT]
                     && i_wdata[CMD_SEL_BIT];
  assign upper_write = wr_take && upper_sel;

  // one access per strobe low phase, however long it is held
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
    end else begin
      wr_prev_reg <= i_io_write_strobe_n;
      rd_prev_reg <= i_io_read_strobe_n;
    end
  end

  // ************************************************************
  // initialization sequence
  // ************************************************************
  init_state_t state_reg;
  init_state_t state_next;
  logic need_options_reg;
  logic single_reg;
  logic level_mode_reg;
  logic [4:0] vector_high_bits_reg;
  logic [7:0] cascade_reg;
  logic [2:0] slave_identity_reg;
  logic vec16_reg;
  logic auto_eoi_reg;
  logic [1:0] buf_mode_reg;
  logic nest_special_reg;
  logic [7:0] mask_reg;

  // the host keeps the word order; the sequence only tracks it
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_READY: state_next = ST_READY;
      ST_VECTOR: begin
        if (upper_write) begin
          if (!single_reg) begin
            state_next = ST_CASCADE;
          end else if (need_options_reg) begin
            state_next = ST_OPTIONS;
          end else begin
            state_next = ST_READY;
          end
        end
      end
      ST_CASCADE: begin
        if (upper_write) begin
          state_next = need_options_reg ? ST_OPTIONS : ST_READY;
        end
      end
      ST_OPTIONS: begin
        if (upper_write) begin
          state_next = ST_READY;
        end
      end
      default: state_next = ST_READY;
    endcase
    if (init_write) begin
      state_next = ST_VECTOR;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_READY;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      need_options_reg <= 1'b0;
      single_reg <= 1'b1;
      level_mode_reg <= 1'b0;
    end else if (init_write) begin
      need_options_reg <= !i_wdata[NO_OPTIONS_BIT];
      single_reg <= i_wdata[SINGLE_BIT];
      level_mode_reg <= i_wdata[LEVEL_MODE_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vector_high_bits_reg <= 5'h00;
      cascade_reg <= 8'h00;
      slave_identity_reg <= 3'h0;
    end else if (upper_write && state_reg == ST_VECTOR) begin
      vector_high_bits_reg <= i_wdata[7:VEC_HIGH_LSB];
    end else if (upper_write && state_reg == ST_CASCADE) begin
      cascade_reg <= i_wdata;
      slave_identity_reg <= i_wdata[2:0];
    end
  end

  // without an options word every option falls back to zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vec16_reg <= 1'b0;
      auto_eoi_reg <= 1'b0;
      buf_mode_reg <= 2'h0;
      nest_special_reg <= 1'b0;
    end else if (init_write) begin
      vec16_reg <= 1'b0;
      auto_eoi_reg <= 1'b0;
      buf_mode_reg <= 2'h0;
      nest_special_reg <= 1'b0;
    end else if (upper_write && state_reg == ST_OPTIONS) begin
      vec16_reg <= i_wdata[VEC16_BIT];
      auto_eoi_reg <= i_wdata[AUTO_EOI_BIT];
      buf_mode_reg <= i_wdata[BUF_ON_BIT:BUF_SEL_LSB];
      nest_special_reg <= i_wdata[NEST_SPECIAL_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_reg <= MASK_RESET;
    end else if (init_write) begin
      mask_reg <= MASK_RESET;
    end else if (upper_write && state_reg == ST_READY) begin
      mask_reg <= i_wdata;
    end
  end

  // ************************************************************
  // command words
  // ************************************************************
  logic [1:0] read_sel_reg;
  logic special_mask_reg;
  logic poll_reg;
  logic auto_rotate_reg;
  logic [2:0] lowest_reg;
  logic [2:0] target_level;
  logic [2:0] eoi_op;

  assign target_level = i_wdata[2:0];
  assign eoi_op = i_wdata[7:5];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_sel_reg <= RSEL_PENDING;
      special_mask_reg <= 1'b0;
    end else if (init_write) begin
      read_sel_reg <= RSEL_PENDING;
      special_mask_reg <= 1'b0;
    end else if (rpm_write) begin
      if (i_wdata[1]) begin
        read_sel_reg <= i_wdata[1:0];
      end
      if (i_wdata[6]) begin
        special_mask_reg <= i_wdata[5];
      end
    end
  end

  // ************************************************************
  // requests, priority and service
  // ************************************************************
  logic [WIDTH-1:0] pending;
  logic [WIDTH-1:0] ack_clear;
  logic [WIDTH-1:0] isr_reg;
  logic req_valid;
  logic [2:0] req_level;
  logic isr_valid;
  logic [2:0] isr_level;
  logic take_ack;
  logic slave_mode;
  logic poll_read;
  logic [2:0] serve_level;

  assign slave_mode = buf_mode_reg[1] ? !buf_mode_reg[0] : i_slave_strap;
  // a slave answers only when the master names it on the cascade lines
  assign take_ack = i_ack && (single_reg || !slave_mode || i_cas_id == slave_identity_reg);
  assign poll_read = rd_take && lower_sel && poll_reg;
  assign serve_level = req_valid ? req_level : DEFAULT_LEVEL;
  assign ack_clear = (take_ack || poll_read) && req_valid ? WIDTH'(1) << req_level : '0;

  request_latch #(.WIDTH(WIDTH)) u_latch (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_req(i_irq),
    .i_level_mode(level_mode_reg),
    .i_clear_all(init_write),
    .i_ack_clear(ack_clear),
    .o_pending(pending)
  );

  priority_resolver #(.WIDTH(WIDTH)) u_resolver (
    .i_request(pending & ~mask_reg),
    .i_in_service(isr_reg),
    .i_lowest(lowest_reg),
    .i_special_mask(special_mask_reg),
    .i_nest_pass(nest_special_reg && !slave_mode ? cascade_reg : '0),
    .o_req_valid(req_valid),
    .o_req_level(req_level),
    .o_isr_valid(isr_valid),
    .o_isr_level(isr_level)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      isr_reg <= '0;
    end else if (init_write) begin
      isr_reg <= '0;
    end else begin
      if (eoi_write) begin
        case (eoi_op)
          OP_NONSPEC_EOI, OP_ROT_NONSPEC: isr_reg[isr_level] <= 1'b0;
          OP_SPEC_EOI, OP_ROT_SPEC: isr_reg[target_level] <= 1'b0;
          default: isr_reg <= isr_reg;
        endcase
      end
      // automatic end does not mark the acknowledged level in service; poll reads still do
      if ((take_ack || poll_read) && req_valid && !(auto_eoi_reg && !poll_read)) begin
        isr_reg[req_level] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lowest_reg <= LOWEST_RESET;
      auto_rotate_reg <= 1'b0;
    end else if (init_write) begin
      lowest_reg <= LOWEST_RESET;
      auto_rotate_reg <= 1'b0;
    end else if (eoi_write) begin
      case (eoi_op)
        OP_SET_AUTO_ROT: auto_rotate_reg <= 1'b1;
        OP_CLR_AUTO_ROT: auto_rotate_reg <= 1'b0;
        OP_ROT_NONSPEC: lowest_reg <= isr_valid ? isr_level : lowest_reg;
        OP_ROT_SPEC, OP_SET_LOWEST: lowest_reg <= target_level;
        default: lowest_reg <= lowest_reg;
      endcase
    end else if (take_ack && req_valid && auto_eoi_reg && auto_rotate_reg) begin
      lowest_reg <= req_level;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      poll_reg <= 1'b0;
    end else if (rpm_write) begin
      poll_reg <= i_wdata[POLL_BIT];
    end else if (init_write || poll_read) begin
      poll_reg <= 1'b0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic to_slave;

  assign to_slave = !single_reg && !slave_mode && req_valid && cascade_reg[req_level];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (rd_take) begin
      if (upper_sel) begin
        o_rdata <= mask_reg;
      end else if (poll_reg) begin
        o_rdata <= {req_valid, 4'h0, req_level};
      end else if (read_sel_reg == RSEL_SERVICE) begin
        o_rdata <= isr_reg;
      end else begin
        o_rdata <= pending;
      end
    end
  end

  // 8-bit mode carries the level in bits 2..0 with the high bits zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vector <= 8'h00;
      o_vector_valid <= 1'b0;
      o_cas_id <= 3'h0;
      o_cas_en <= 1'b0;
    end else begin
      o_vector_valid <= take_ack && !to_slave;
      o_cas_en <= take_ack && to_slave;
      if (take_ack) begin
        o_vector <= vec16_reg ? {vector_high_bits_reg, serve_level}
                              : {5'h00, serve_level};
        o_cas_id <= serve_level;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_int <= 1'b0;
      o_buf_en <= 1'b0;
      o_buf_master <= 1'b0;
    end else begin
      o_int <= req_valid && state_reg == ST_READY;
      o_buf_en <= buf_mode_reg[1] && (rd_take || take_ack);
      o_buf_master <= buf_mode_reg == 2'h3;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  a_init_restart: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    init_write |=> state_reg == ST_VECTOR && isr_reg == '0)
    else $error("init word did not restart sequence");

  a_mask_load: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (upper_write && state_reg == ST_READY) |=> mask_reg == $past(i_wdata))
    else $error("mask not loaded");

  a_spec_eoi: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (eoi_write && eoi_op == OP_SPEC_EOI && !take_ack && !poll_read)
      |=> !isr_reg[$past(target_level)])
    else $error("specific end left level in service");

  a_set_lowest: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (eoi_write && eoi_op == OP_SET_LOWEST) |=> lowest_reg == $past(target_level))
    else $error("lowest priority not set");

  a_read_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rpm_write && i_wdata[1:0] == RSEL_SERVICE) ##2 (rd_take && lower_sel && !poll_reg)
      |=> o_rdata == $past(isr_reg))
    else $error("in-service read wrong");

  a_special_mask: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rpm_write && i_wdata[6:5] == 2'h3) |=> special_mask_reg)
    else $error("special mask not entered");

  a_vector_form: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take_ack && vec16_reg && !to_slave)
      |=> o_vector_valid && o_vector == {$past(vector_high_bits_reg), $past(serve_level)})
    else $error("vector malformed");

  a_auto_eoi: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (take_ack && auto_eoi_reg && req_valid && !eoi_write && !init_write
      && !isr_reg[req_level]) |=> !isr_reg[$past(req_level)])
    else $error("automatic end left level in service");

  a_cascade_walk: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (upper_write && state_reg == ST_VECTOR && !single_reg && !init_write)
      |=> state_reg == ST_CASCADE)
    else $error("cascade word skipped");
endmodule
`default_nettype wire

/* tb/host_bus_model.sv */
// host processor model: byte writes and reads on the two i/o ports
// assumes calls start just after a rising edge of i_clk
`default_nettype none
module host_bus_model import pic_pkg::*; (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_cs,
  output logic [7:0] o_addr,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_cs = 1'b0;
    o_addr = 8'h00;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_wdata = 8'h00;
  end
  // one strobe-low cycle, then one high cycle before the next access
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    o_cs = 1'b1;
    o_addr = a;
    o_wdata = d;
    o_wr_n = !wr;
    o_rd_n = wr;
    @(posedge i_clk);
    #1;
    o_cs = 1'b0;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    // released lines show junk, not the last value
    o_addr = ~a;
    o_wdata = ~d;
    @(posedge i_clk);
    #1;
    q = i_rdata;
  endtask
  task automatic init(input logic [7:0] w1, w2, w3, w4);
    logic [7:0] q;
    access(1'b1, LOWER_PORT, w1, q);
    access(1'b1, UPPER_PORT, w2, q);
    if (!w1[1]) access(1'b1, UPPER_PORT, w3, q);
    if (!w1[0]) access(1'b1, UPPER_PORT, w4, q);
  endtask
endmodule
`default_nettype wire

/* tb/tb_prioritized_interrupt_controller.sv */
// self-checking bench for the interrupt controller
// assumes the host model drives the bus; cascade identity driven by the bench
`default_nettype none
module tb_prioritized_interrupt_controller import pic_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs, wr_n, rd_n, ack = 1'b0, irq_out, vector_valid, cas_en, buf_en, buf_master;
  logic [7:0] addr, wdata, rdata, vector, irq = 8'h00, v, q;
  logic [2:0] cas_id_out;
  logic [2:0] cas_in = 3'h0;
  logic be;
  logic [1:0] c;
  int num_errors = 0;
  int samples_checked = 0;
  always #10 clk = ~clk;
  host_bus_model host_u (.i_clk(clk), .i_rdata(rdata), .o_cs(cs), .o_addr(addr),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_wdata(wdata));
  interrupt_controller dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_cs(cs), .i_addr(addr),
    .i_io_write_strobe_n(wr_n), .i_io_read_strobe_n(rd_n), .i_wdata(wdata),
    .i_irq(irq), .i_ack(ack), .i_slave_strap(1'b0), .i_cas_id(cas_in), .o_rdata(rdata),
    .o_int(irq_out), .o_vector(vector), .o_vector_valid(vector_valid),
    .o_cas_id(cas_id_out), .o_cas_en(cas_en), .o_buf_en(buf_en),
    .o_buf_master(buf_master));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.access(1'b0, a, 8'h00, q);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  // ack pulse, then catch the vector or cascade pulse within three edges
  task automatic take_ack();
    ack = 1'b1;
    @(posedge clk);
    #1;
    ack = 1'b0;
    c = 2'b00;
    v = 8'h00;
    be = 1'b0;
    for (int n = 0; n < 3; n++) begin
      if (buf_en === 1'b1) begin
        be = 1'b1;
      end
      if (vector_valid === 1'b1 || cas_en === 1'b1) begin
        v = cas_en ? {5'h00, cas_id_out} : vector;
        c = {vector_valid, cas_en};
      end
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_mask();
    rd(UPPER_PORT);
    chk(q, MASK_RESET);
    host_u.init(8'h13, 8'h48, 8'h00, 8'h00);
    wr(UPPER_PORT, 8'ha5);
    rd(UPPER_PORT);
    chk(q, 8'ha5);
    irq = 8'h01;
    settle();
    chk({7'h00, irq_out}, 8'h00);
    irq = 8'h03;
    settle();
    chk({7'h00, irq_out}, 8'h01);
    host_u.init(8'h13, 8'h48, 8'h00, 8'h00);
    settle();
    chk({7'h00, irq_out}, 8'h00);
    irq = 8'h00;
  endtask
  task automatic t_vector();
    logic [2:0] lvl;
    host_u.init(8'h12, 8'h48, 8'h00, 8'h01);
    take_ack();
    chk(v, 8'h4f);
    for (int k = 0; k < 2; k++) begin
      lvl = k ? 3'h5 : 3'h3;
      irq[lvl] = 1'b1;
      settle();
      chk({7'h00, irq_out}, 8'h01);
      take_ack();
      chk(v, {5'h09, lvl});
      chk({6'h00, c}, 8'h02);
      wr(LOWER_PORT, 8'h0b);
      rd(LOWER_PORT);
      chk(q, 8'h01 << lvl);
      wr(LOWER_PORT, {k ? OP_NONSPEC_EOI : OP_SPEC_EOI, 2'b00, lvl});
      rd(LOWER_PORT);
      chk(q, 8'h00);
      irq[lvl] = 1'b0;
    end
  endtask
  task automatic t_auto();
    host_u.init(8'h12, 8'h48, 8'h00, 8'h03);
    irq = 8'h04;
    settle();
    take_ack();
    chk(v, 8'h4a);
    chk({7'h00, be}, 8'h00);
    wr(LOWER_PORT, 8'h0b);
    rd(LOWER_PORT);
    chk(q, 8'h00);
    irq = 8'h00;
  endtask
  task automatic t_cascade();
    host_u.init(8'h10, 8'h48, 8'h04, 8'h0d);
    chk({7'h00, buf_master}, 8'h01);
    irq = 8'h04;
    settle();
    take_ack();
    chk({6'h00, c}, 8'h01);
    chk(v, 8'h02);
    irq = 8'h00;
  endtask
  task automatic t_level();
    host_u.init(8'h1b, 8'h48, 8'h00, 8'h00);
    irq = 8'h10;
    settle();
    take_ack();
    wr(LOWER_PORT, {OP_NONSPEC_EOI, 5'h00});
    settle();
    chk({7'h00, irq_out}, 8'h01);
    irq = 8'h00;
  endtask
  // rotated priority, poll, special mask
  task automatic t_misc();
    host_u.init(8'h13, 8'h48, 8'h00, 8'h00);
    wr(LOWER_PORT, {OP_SET_LOWEST, 2'b00, 3'h2});
    irq = 8'h0a;
    settle();
    wr(LOWER_PORT, 8'h0c);
    rd(LOWER_PORT);
    chk(q, 8'h83);
    wr(LOWER_PORT, 8'h68);
    settle();
    chk({7'h00, irq_out}, 8'h01);
    wr(LOWER_PORT, 8'h48);
    settle();
    chk({7'h00, irq_out}, 8'h00);
    irq = 8'h00;
  endtask
  // buffered slave answers only its own identity
  task automatic t_slave();
    host_u.init(8'h10, 8'h48, 8'h05, 8'h09);
    chk({7'h00, buf_master}, 8'h00);
    irq = 8'h02;
    settle();
    take_ack();
    chk({6'h00, c}, 8'h00);
    cas_in = 3'h5;
    take_ack();
    chk(v, 8'h49);
    chk({7'h00, be}, 8'h01);
    cas_in = 3'h0;
    irq = 8'h00;
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_mask();
    t_vector();
    t_auto();
    t_cascade();
    t_level();
    t_misc();
    t_slave();
    give_verdict();
  end
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
